/* dv/lscd_decoder_tb_top.sv */
// self-checking testbench of the serial command decoder
`timescale 1ns/10ps
`default_nettype none
module lscd_decoder_tb_top;
    logic        clock;     // 10 MHz system clock
    logic        rstn;      // synchronous reset, active low
    logic [1:0]  scan_row;  // row picked for seg_out
    wire logic   sck;       // link clock from host
    wire logic   sdi;       // serial data from host
    wire logic   cs_n;      // chip select from host
    wire logic   cd;        // command or data select
    logic [31:0] seg_out;   // segment states
    logic [4:0]  addr_out;  // address counter
    logic [1:0]  mode_out;  // display mode
    logic        buf_full;  // buffer full flag
    int          err_count; // mismatches
    int          checks;    // comparisons made

    lscd_host_model host (
        .clock (clock), .sck (sck), .sdi (sdi), .cs_n (cs_n), .cd (cd)
    );

    lscd_decoder dut (
        .clock (clock), .rstn (rstn), .serial_shift_clock (sck),
        .serial_in (sdi), .chip_sel_n (cs_n), .cmd_data_sel (cd),
        .scan_row (scan_row), .seg_out (seg_out), .addr_out (addr_out),
        .mode_out (mode_out), .buf_full (buf_full)
    );

    // clock generator
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // one comparison, reported at once on mismatch
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    // whole byte, then time for buffer, decoder and segment update
    task automatic send(input logic c, input logic [7:0] b);
        host.frame(c, b, 8);
        repeat (8) @(posedge clock);
    endtask : send

    // read one memory word through the four scan rows
    task automatic seg_bit(input int g, input logic [3:0] w);
        for (int r = 0; r < 4; r++) begin
            scan_row <= 2'(r);
            repeat (3) @(posedge clock);
            chk(seg_out[g] === w[r], "segment bit differs");
        end
    endtask : seg_bit

    // state after reset
    task automatic t_reset();
        chk(addr_out === 5'h00 && buf_full === 1'b0, "reset addr or buffer");
        chk(mode_out === lscd_pkg::LSCD_ALL_OFF, "reset mode");
        chk(seg_out === 32'h00000000, "reset segments");
    endtask : t_reset

    // address set at the top, data bytes wrapping round
    task automatic t_addr_data();
        send(1'b1, 8'h1F);
        chk(addr_out === 5'h1F, "address set");
        send(1'b1, 8'h60);
        send(1'b0, 8'h5A);
        chk(mode_out === lscd_pkg::LSCD_NORMAL, "data taken as cmd");
        chk(addr_out === 5'h01, "byte step or wrap");
        send(1'b0, 8'h3C);
        chk(addr_out === 5'h03 && buf_full === 1'b0, "back to back");
        seg_bit(31, 4'h5);
        seg_bit(0, 4'hA);
        seg_bit(2, 4'hC);
    endtask : t_addr_data

    // four bit write with bit 4 set
    task automatic t_write4();
        send(1'b1, 8'h02);
        send(1'b1, 8'h93);
        chk(addr_out === 5'h03, "nibble step");
        seg_bit(2, 4'h3);
        seg_bit(1, 4'h3);
    endtask : t_write4

    // every display mode, undefined code 7 and the reset command
    task automatic t_modes();
        send(1'b1, 8'h3F);
        chk(mode_out === lscd_pkg::LSCD_ALL_ON, "all on mode");
        chk(seg_out === 32'hFFFFFFFF && addr_out === 5'h03, "all on");
        send(1'b1, 8'hFF);
        chk(mode_out === lscd_pkg::LSCD_ALL_ON, "code 7 mode");
        chk(addr_out === 5'h03, "code 7 address");
        send(1'b1, 8'h5F);
        chk(mode_out === lscd_pkg::LSCD_ALL_OFF, "all off mode");
        chk(seg_out === 32'h00000000, "all off");
        send(1'b1, 8'h7F);
        send(1'b1, 8'hDF);
        chk(addr_out === 5'h00, "reset cmd address");
        chk(mode_out === lscd_pkg::LSCD_ALL_OFF, "reset cmd mode");
        send(1'b1, 8'h7F);
        chk(mode_out === lscd_pkg::LSCD_NORMAL, "display start");
        seg_bit(31, 4'h5);
    endtask : t_modes

    // aborted frame, then a full one framed afresh
    task automatic t_cs_restart();
        host.frame(1'b1, 8'h00, 3);
        send(1'b1, 8'h05);
        chk(addr_out === 5'h05, "framing after select");
    endtask : t_cs_restart

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // watchdog well past the expected run
    initial begin
        #3000000;
        err_count++;
        $display("unexpected at %0t: run timed out", $time);
        finish_test();
    end

    // main sequence
    initial begin
        rstn      = 1'b0;
        scan_row  = 2'h0;
        err_count = 0;
        checks    = 0;
        repeat (10) @(posedge clock);
        t_reset();
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        t_addr_data();
        t_write4();
        t_modes();
        t_cs_restart();
        finish_test();
    end
endmodule : lscd_decoder_tb_top
`default_nettype wire

/* dv/lscd_host_model.sv */
// host model that shifts bytes into the decoder over the serial link
`timescale 1ns/10ps
`default_nettype none
module lscd_host_model (
    // system
    input  wire logic clock,
    // serial link pins
    output logic      sck,
    output logic      sdi,
    output logic      cs_n,
    output logic      cd
);
    // link idles deselected with its clock standing low
    initial begin
        sck  = 1'b0;
        sdi  = 1'b0;
        cs_n = 1'b1;
        cd   = 1'b0;
    end

    // one frame of n bits, 4 clocks low and 4 high per link period
    task automatic frame(input logic c, input logic [7:0] b, input int n);
        @(posedge clock);
        cs_n <= 1'b0; // select falls before first edge
        repeat (4) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            sck <= 1'b0;
            sdi <= b[7-i]; // msb first, lsb last
            cd  <= c;
            repeat (4) @(posedge clock);
            sck <= 1'b1; // rising edge shifts the bit
            repeat (4) @(posedge clock);
        end
        // released lines show the inverse, not the old value
        sck <= 1'b0;
        sdi <= ~sdi;
        cd  <= ~c;
        repeat (4) @(posedge clock);
        cs_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : frame
endmodule : lscd_host_model
`default_nettype wire

/* hdl/lscd_decoder.sv */
// serial command and data receiver with command decoder and display memory
`timescale 1ns/10ps
`default_nettype none
module lscd_decoder (
    // system
    input  wire logic         clock,
    input  wire logic         rstn,
    // serial link pins, asynchronous to clock
    input  wire logic         serial_shift_clock,
    input  wire logic         serial_in,
    input  wire logic         chip_sel_n,
    input  wire logic         cmd_data_sel,
    // memory read port for the segment scanner
    input  wire logic [1:0]   scan_row,
    output logic [31:0]       seg_out,
    // status
    output logic [4:0]        addr_out,
    output logic [1:0]        mode_out,
    output logic              buf_full
);
    // two stage synchronisers for every serial link pin
    logic [1:0] sclk_s_q;       // shift clock sync
    logic [1:0] si_s_q;         // data sync
    logic [1:0] cs_s_q;         // chip select sync
    logic [1:0] cd_s_q;         // command/data sync
    logic       sclk_prev_q;    // last synced clock level
    logic       cs_prev_q;      // last synced select level
    logic       sclk_rise;      // shift clock rising edge
    logic       cs_fall;        // chip select falling edge
    // byte assembly
    logic [2:0] bit_cnt_q;      // edges counted in byte
    logic [6:0] shift_q;        // first seven bits
    logic       byte_vld;       // complete byte this cycle
    logic [8:0] byte_word;      // select flag and byte
    // two entry buffer
    logic [8:0] buf_mem_q [lscd_pkg::BUF_DEPTH];
    logic       wr_ptr_q;       // write slot
    logic       rd_ptr_q;       // read slot
    logic [1:0] cnt_q;          // entries held
    logic       buf_in_rdy;     // space for a byte
    logic       buf_out_vld;    // a byte waiting
    logic       buf_out_rdy;    // decoder takes it
    logic [8:0] head;           // byte at the head
    logic       take;           // head consumed
    // decoder state
    logic [4:0] addr_q;         // address counter
    lscd_pkg::lscd_mode_t mode_q;   // display mode
    logic [3:0] mem_q [lscd_pkg::DEPTH];    // display memory
    logic       nib_pend_q;     // lower nibble still to write
    logic [3:0] nib_lo_q;       // held lower nibble
    logic [31:0] seg_d;         // next segment word

    // checks sample on the system clock and rest during reset
    default clocking sys_cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // synchronise pins before use
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclk_s_q <= 2'h0;
            si_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            cd_s_q <= 2'h0;
            sclk_prev_q <= 1'h0;
            cs_prev_q <= 1'h1;
        end else begin
            sclk_s_q <= {sclk_s_q[0], serial_shift_clock};
            si_s_q <= {si_s_q[0], serial_in};
            cs_s_q <= {cs_s_q[0], chip_sel_n};
            cd_s_q <= {cd_s_q[0], cmd_data_sel};
            sclk_prev_q <= sclk_s_q[1];
            cs_prev_q <= cs_s_q[1];
        end
    end

    // edge detectors on synced levels only
    assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
    assign cs_fall = ~cs_s_q[1] & cs_prev_q;
    assign byte_vld = sclk_rise & ~cs_s_q[1]
                      & (bit_cnt_q == lscd_pkg::BIT_LAST);
    // select flag captured with the eighth bit
    assign byte_word = {cd_s_q[1], shift_q, si_s_q[1]};

    // bit counter and shift register, msb first
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (cs_fall) begin
            bit_cnt_q <= 3'h0;
        end else if (sclk_rise && !cs_s_q[1]) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;            // wraps after eight
            shift_q <= {shift_q[5:0], si_s_q[1]};
        end
    end

    // buffer handshakes; a byte finished while the buffer is full is dropped
    assign buf_in_rdy = (cnt_q != 2'(lscd_pkg::BUF_DEPTH));
    assign buf_out_vld = (cnt_q != 2'h0);
    assign buf_full = ~buf_in_rdy;
    assign head = buf_mem_q[rd_ptr_q];
    assign buf_out_rdy = ~nib_pend_q;
    assign take = buf_out_vld & buf_out_rdy;

    // buffer storage and pointers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_ptr_q <= 1'h0;
            rd_ptr_q <= 1'h0;
            cnt_q <= 2'h0;
            buf_mem_q[0] <= 9'h000;
            buf_mem_q[1] <= 9'h000;
        end else begin
            if (byte_vld && buf_in_rdy) begin
                buf_mem_q[wr_ptr_q] <= byte_word;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (take) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + 2'(byte_vld && buf_in_rdy) - 2'(take);
        end
    end

    // address counter; five bit arithmetic wraps 31 to 0
    always_ff @(posedge clock) begin
        if (!rstn) begin
            addr_q <= lscd_pkg::ADDR_RST;
        end else if (nib_pend_q) begin
            addr_q <= addr_q + lscd_pkg::STEP_NIB;
        end else if (take && !head[8]) begin
            addr_q <= addr_q + lscd_pkg::STEP_NIB;    // first of two steps
        end else if (take) begin
            case (head[7:5])
                lscd_pkg::OP_ADDR:
                    addr_q <= head[4:0];
                lscd_pkg::OP_WRITE4:
                    addr_q <= addr_q + lscd_pkg::STEP_NIB;
                lscd_pkg::OP_RESET:
                    addr_q <= lscd_pkg::ADDR_RST;
                default:
                    addr_q <= addr_q;
            endcase
        end
    end

    // pending lower nibble of a data byte
    always_ff @(posedge clock) begin
        if (!rstn) begin
            nib_pend_q <= 1'h0;
            nib_lo_q <= 4'h0;
        end else if (nib_pend_q) begin
            nib_pend_q <= 1'h0;
        end else if (take && !head[8]) begin
            nib_pend_q <= 1'h1;
            nib_lo_q <= head[3:0];
        end
    end

    // display memory writes, one nibble per cycle
    always_ff @(posedge clock) begin
        if (nib_pend_q) begin
            mem_q[addr_q] <= nib_lo_q;
        end else if (take && !head[8]) begin
            mem_q[addr_q] <= head[7:4];
        end else if (take && head[7:5] == lscd_pkg::OP_WRITE4) begin
            mem_q[addr_q] <= head[3:0];
        end
    end

    // display mode
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_q <= lscd_pkg::LSCD_ALL_OFF;
        end else if (take && head[8]) begin
            case (head[7:5])
                lscd_pkg::OP_DISP_ON:
                    mode_q <= lscd_pkg::LSCD_ALL_ON;
                lscd_pkg::OP_DISP_OF:
                    mode_q <= lscd_pkg::LSCD_ALL_OFF;
                lscd_pkg::OP_START:
                    mode_q <= lscd_pkg::LSCD_NORMAL;
                lscd_pkg::OP_RESET:
                    mode_q <= lscd_pkg::LSCD_ALL_OFF;
                default:
                    mode_q <= mode_q;
            endcase
        end
    end

    // segment word for the selected common row
    genvar g;
    generate
        for (g = 0; g < lscd_pkg::SEG_W; g++) begin : g_seg
            always_comb begin
                case (mode_q)
                    lscd_pkg::LSCD_ALL_ON:  seg_d[g] = 1'h1;
                    lscd_pkg::LSCD_ALL_OFF: seg_d[g] = 1'h0;
                    default:                seg_d[g] = mem_q[g][scan_row];
                endcase
            end
        end
    endgenerate

    // registered outputs
    always_ff @(posedge clock) begin
        if (!rstn) begin
            seg_out <= 32'h0000_0000;
        end else begin
            seg_out <= seg_d;
        end
    end
    assign addr_out = addr_q;
    assign mode_out = mode_q;

    // address set takes the five bit field as is
    addr_set_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_ADDR
        |=> addr_q == $past(head[4:0]))
        else $error("address set not loaded");

    // a data byte moves the address by two in all
    byte_step_a: assert property (
        take && !head[8]
        |=> ##1 addr_q == 5'($past(addr_q, 2) + lscd_pkg::STEP_BYTE)
            && !nib_pend_q)
        else $error("data byte did not advance by two");

    // upper nibble lands at the current address
    byte_upper_a: assert property (
        take && !head[8]
        |=> mem_q[$past(addr_q)] == $past(head[7:4]))
        else $error("upper nibble not stored");

    // lower nibble lands one address further on
    byte_lower_a: assert property (
        take && !head[8]
        |=> ##1 mem_q[5'($past(addr_q, 2) + lscd_pkg::STEP_NIB)]
            == $past(head[3:0], 2))
        else $error("lower nibble not stored");

    // the counter rolls from the top address to zero
    addr_wrap_a: assert property (
        take && !head[8] && addr_q == 5'h1F
        |=> addr_q == 5'h00)
        else $error("address did not wrap");

    // forced modes reach the segment register a cycle later
    disp_on_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_DISP_ON
        |=> ##1 seg_out == 32'hFFFF_FFFF)
        else $error("display on not forced");
    disp_off_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_DISP_OF
        |=> ##1 seg_out == 32'h0000_0000)
        else $error("display off not forced");

    // display start hands the segments back to memory
    start_mode_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_START
        |=> mode_q == lscd_pkg::LSCD_NORMAL)
        else $error("display start failed");

    // nibble write stores the low bits and steps by one
    nib_write_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_WRITE4
        |=> addr_q == 5'($past(addr_q) + lscd_pkg::STEP_NIB)
            && mem_q[$past(addr_q)] == $past(head[3:0]))
        else $error("nibble write wrong");

    // reset command clears the address and blanks the display
    reset_cmd_a: assert property (
        take && head[8] && head[7:5] == lscd_pkg::OP_RESET
        |=> addr_q == lscd_pkg::ADDR_RST
            && mode_q == lscd_pkg::LSCD_ALL_OFF)
        else $error("reset command failed");

    // spare code 7 leaves address and mode alone
    undef_cmd_a: assert property (
        take && head[8] && head[7:5] == 3'h7
        |=> $stable(addr_q) && $stable(mode_q))
        else $error("undefined command changed state");

    // select falling restarts byte framing
    cs_restart_a: assert property (
        cs_fall |=> bit_cnt_q == 3'h0)
        else $error("select fall did not restart count");

    // a finished byte always finds room in the buffer
    buf_no_drop_a: assert property (
        byte_vld |-> buf_in_rdy)
        else $error("byte lost at a full buffer");
endmodule : lscd_decoder
`default_nettype wire

/* hdl/lscd_pkg.sv */
// constants and types for the serial command decoder
package lscd_pkg;
    localparam int          ADDR_W     = 5;      // display memory address width
    localparam int          DEPTH      = 32;     // display memory words
    localparam int          WORD_W     = 4;      // bits per memory word
    localparam int          SEG_W      = 32;     // segment outputs
    localparam int          BUF_DEPTH  = 2;      // byte buffer entries
    localparam logic [2:0]  BIT_LAST   = 3'h7;   // count of eighth edge
    localparam logic [2:0]  OP_ADDR    = 3'h0;   // address set
    localparam logic [2:0]  OP_DISP_ON = 3'h1;   // all segments on
    localparam logic [2:0]  OP_DISP_OF = 3'h2;   // all segments off
    localparam logic [2:0]  OP_START   = 3'h3;   // normal display
    localparam logic [2:0]  OP_WRITE4  = 3'h4;   // four bit write
    localparam logic [2:0]  OP_RESET   = 3'h6;   // device reset
    localparam logic [4:0]  ADDR_RST   = 5'h00;  // address after reset
    localparam logic [4:0]  STEP_BYTE  = 5'h02;  // advance per data byte
    localparam logic [4:0]  STEP_NIB   = 5'h01;  // advance per nibble write
    // display modes
    typedef enum logic [1:0] {
        LSCD_NORMAL,
        LSCD_ALL_ON,
        LSCD_ALL_OFF
    } lscd_mode_t;
endpackage : lscd_pkg
